// [hw/mact_params.svh]
// Constants of the memory access cycle timing model
// Assumes one 250 MHz core clock; counts are core clock cycles
`ifndef MACT_PARAMS_SVH
`define MACT_PARAMS_SVH

// Address map
`define MACT_ROM_TOP        16'h5fff
`define MACT_PERIPHERAL_RAM_BASE      16'hfc00
`define MACT_MAIN_BASE      16'hfe00
`define MACT_SFR_BASE       16'hff00
`define MACT_SADDR_SFR_TOP  16'hff1f

// Wait control register fields, three bits per 16K block
`define MACT_WCTL_W         12
`define MACT_WCTL_FLD       3
`define MACT_WCTL_HS_BIT    2
`define MACT_WCTL_RESET     12'h000

// Access costs
`define MACT_MAIN_CLK       8'h01
`define MACT_SFR_CLK        8'h04
`define MACT_SLOW_BASE      8'h03
`define MACT_FAST_FETCH     8'h02
`define MACT_PWR_EU_CLK     8'h01

// Interrupt entry costs
`define MACT_VEC_MAIN       8'h15
`define MACT_VEC_PERIPHERAL_RAM_EVEN  8'h19
`define MACT_VEC_PERIPHERAL_RAM_ODD   8'h21
`define MACT_CTX_SWITCH     8'h11

// Macro service costs
`define MACT_SVC_EVT        8'h0c
`define MACT_SVC_M2S_BYTE   8'h12
`define MACT_SVC_M2S_WORD   8'h13
`define MACT_SVC_S2M_BYTE   8'h11
`define MACT_SVC_S2M_WORD   8'h12

// Correction costs
`define MACT_SADDR_EXTRA    16'h0004
`define MACT_FLUSH_FAST     8'h08
`define MACT_FLUSH_SLOW     8'h0a

`endif

// [hw/mact_pkg.sv]
// Types of the memory access cycle timing model
// Assumes the constants header is included by each design file
package mact_pkg;

  typedef enum logic [2:0] {
    OP_FETCH   = 3'h0,
    OP_READ    = 3'h1,
    OP_WRITE   = 3'h2,
    OP_IRQ_VEC = 3'h3,
    OP_IRQ_CTX = 3'h4,
    OP_MACRO   = 3'h5,
    OP_BRANCH  = 3'h6
  } mact_op_type;

  typedef enum logic [2:0] {
    SVC_EVT      = 3'h0,
    SVC_M2S_BYTE = 3'h1,
    SVC_M2S_WORD = 3'h2,
    SVC_S2M_BYTE = 3'h3,
    SVC_S2M_WORD = 3'h4
  } mact_svc_type;

  typedef enum logic [2:0] {
    AREA_ROM  = 3'h0,
    AREA_GAP  = 3'h1,
    AREA_PERIPHERAL_RAM = 3'h2,
    AREA_MAIN = 3'h3,
    AREA_SFR  = 3'h4
  } mact_area_type;

  typedef enum logic [1:0] {
    CLS_NONE   = 2'h0,
    CLS_SINGLE = 2'h1,
    CLS_DOUBLE = 2'h2,
    CLS_MEMMEM = 2'h3
  } mact_class_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARB   = 4'b0010,
    ST_STALL = 4'b0100,
    ST_COUNT = 4'b1000
  } mact_state_type;

endpackage : mact_pkg

// [hw/mact_cycle_timer.sv]
// Down counter that marks the last cycle of a timed access
// Assumes load only while the counter is idle
`include "mact_params.svh"

module mact_cycle_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Load
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  // Status
  output logic            last
);
  import mact_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
  } mact_tmr_type;

  mact_tmr_type st;
  mact_tmr_type next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = load_val;
    end else if (st.cnt != 8'h00) begin
      next_st.cnt = st.cnt - 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign last = (st.cnt == 8'h01);

endmodule : mact_cycle_timer

// [hw/mact_top.sv]
// Cycle timing model of internal memory accesses and latencies
// Assumes the execution unit issues one request at a time
`include "mact_params.svh"

module mact_top (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  // Wait control register load
  input  wire logic                    wctl_wr,
  input  wire logic [11:0]             wctl_data,
  output logic      [11:0]             wait_control_reg,
  // Access request
  input  wire logic                    req_valid,
  input  wire mact_pkg::mact_op_type   req_op,
  input  wire logic [15:0]             req_addr,
  input  wire mact_pkg::mact_svc_type  req_svc,
  output logic                         req_ready,
  // Access completion
  output logic                         acc_done,
  output logic                         acc_error,
  output logic      [7:0]              acc_cycles,
  // Execution clock calculation
  input  wire logic                    calc_valid,
  input  wire logic [1:0]              calc_region,
  input  wire logic [15:0]             calc_instr_clocks,
  input  wire logic [7:0]              calc_instr_bytes,
  input  wire mact_pkg::mact_class_type calc_class,
  input  wire logic [15:0]             calc_opnd_a,
  input  wire logic [15:0]             calc_opnd_b,
  input  wire logic [3:0]              calc_mm_cnt,
  input  wire logic [3:0]              calc_wctl_cnt,
  input  wire logic                    calc_branch,
  output logic                         calc_done,
  output logic      [15:0]             calc_clocks
);
  import mact_pkg::*;

  typedef struct packed {
    mact_state_type state;
    logic           ready;
    logic           done;
    logic           err;
    logic [7:0]     cycles;
    logic [7:0]     bus_hold;
    logic [7:0]     bus_cnt;
    logic           arb;
    logic [11:0]    wctl;
    logic           calc_done;
    logic [15:0]    calc_clocks;
  } mact_top_type;

  mact_top_type st;
  mact_top_type next_st;

  logic           tmr_load;
  logic [7:0]     tmr_val;
  logic           tmr_last;
  mact_area_type  req_area;
  logic [1:0]     req_n;
  logic           req_hs;
  logic [7:0]     req_cost;
  logic           req_bad;
  logic           req_peripheral_ram_data;
  logic [15:0]    calc_total;
  logic [2:0]     req_fld;
  logic [2:0]     calc_fld;

  ////////////////////////////////////////////////////////////////////////////
  // Address and region decode

  function automatic mact_area_type area_of(input logic [15:0] a);
    if (a <= `MACT_ROM_TOP) begin
      area_of = AREA_ROM;
    end else if (a < `MACT_PERIPHERAL_RAM_BASE) begin
      area_of = AREA_GAP;
    end else if (a < `MACT_MAIN_BASE) begin
      area_of = AREA_PERIPHERAL_RAM;
    end else if (a < `MACT_SFR_BASE) begin
      area_of = AREA_MAIN;
    end else begin
      area_of = AREA_SFR;
    end
  endfunction : area_of

  function automatic logic [2:0] field_of(input logic [11:0] w, input logic [1:0] r);
    field_of = w[r*`MACT_WCTL_FLD +: `MACT_WCTL_FLD];
  endfunction : field_of

  assign req_area      = area_of(req_addr);
  assign req_fld       = field_of(st.wctl, req_addr[15:14]);
  assign calc_fld      = field_of(st.wctl, calc_region);
  assign req_n         = req_fld[1:0];
  assign req_hs        = req_fld[`MACT_WCTL_HS_BIT];
  assign req_peripheral_ram_data = (req_area == AREA_PERIPHERAL_RAM) && (req_op == OP_READ || req_op == OP_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // Request cost

  always_comb begin
    req_cost = `MACT_MAIN_CLK;
    req_bad  = 1'b0;
    case (req_op)
      OP_FETCH: begin
        if (req_area == AREA_ROM || req_area == AREA_PERIPHERAL_RAM) begin
          req_cost = req_hs ? `MACT_FAST_FETCH : `MACT_SLOW_BASE + {6'h00, req_n};
        end else begin
          req_bad = 1'b1;
        end
      end
      OP_READ, OP_WRITE: begin
        case (req_area)
          AREA_MAIN: req_cost = `MACT_MAIN_CLK;
          AREA_SFR: req_cost = `MACT_SFR_CLK;
          AREA_ROM: begin
            req_cost = `MACT_SLOW_BASE + {6'h00, req_n};
            req_bad  = (req_op == OP_WRITE);
          end
          AREA_PERIPHERAL_RAM: begin
            // Write hands off in one clock
            req_cost = (req_op == OP_WRITE) ? `MACT_PWR_EU_CLK
                                            : `MACT_SLOW_BASE + {6'h00, req_n};
          end
          default: req_bad = 1'b1;
        endcase
      end
      OP_IRQ_VEC: begin
        case (req_area)
          AREA_MAIN: req_cost = `MACT_VEC_MAIN + {5'h00, req_n, 1'b0};
          AREA_PERIPHERAL_RAM: req_cost = (req_addr[0] ? `MACT_VEC_PERIPHERAL_RAM_ODD : `MACT_VEC_PERIPHERAL_RAM_EVEN)
                                + {5'h00, req_n, 1'b0};
          default:   req_bad  = 1'b1;
        endcase
      end
      OP_IRQ_CTX: req_cost = `MACT_CTX_SWITCH + {5'h00, req_n, 1'b0};
      OP_MACRO: begin
        case (req_svc)
          SVC_EVT:      req_cost = `MACT_SVC_EVT;
          SVC_M2S_BYTE: req_cost = `MACT_SVC_M2S_BYTE;
          SVC_M2S_WORD: req_cost = `MACT_SVC_M2S_WORD;
          SVC_S2M_BYTE: req_cost = `MACT_SVC_S2M_BYTE;
          SVC_S2M_WORD: req_cost = `MACT_SVC_S2M_WORD;
          default:      req_bad  = 1'b1;
        endcase
      end
      OP_BRANCH: req_cost = req_hs ? `MACT_FLUSH_FAST : `MACT_FLUSH_SLOW + {6'h00, req_n};
      default: req_bad = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution clock calculation

  always_comb begin
    logic [2:0]  f;
    logic [15:0] n16;
    logic [15:0] byte_clk;
    logic [15:0] basic;
    logic [15:0] sfr_cnt;
    logic        in_a;
    logic        in_b;
    f        = calc_fld;
    basic    = 16'h0000;
    sfr_cnt  = 16'h0000;
    in_a     = 1'b0;
    in_b     = 1'b0;
    n16      = {14'h0000, f[1:0]};
    byte_clk = {8'h00, calc_instr_bytes} * (16'h0003 + n16);
    basic = (f[`MACT_WCTL_HS_BIT] || calc_instr_clocks > byte_clk) ? calc_instr_clocks
                                                                    : byte_clk;
    in_a = (calc_opnd_a >= `MACT_SFR_BASE) && (calc_opnd_a <= `MACT_SADDR_SFR_TOP);
    in_b = (calc_opnd_b >= `MACT_SFR_BASE) && (calc_opnd_b <= `MACT_SADDR_SFR_TOP);
    case (calc_class)
      CLS_SINGLE: sfr_cnt = {15'h0000, in_a};
      CLS_DOUBLE: sfr_cnt = {14'h0000, in_a, 1'b0};
      CLS_MEMMEM: sfr_cnt = {15'h0000, in_a} + {15'h0000, in_b};
      default:    sfr_cnt = 16'h0000;
    endcase
    calc_total = basic + sfr_cnt * `MACT_SADDR_EXTRA;
    if (f[`MACT_WCTL_HS_BIT]) begin
      calc_total = calc_total + {12'h000, calc_wctl_cnt};
    end else begin
      calc_total = calc_total + {12'h000, calc_mm_cnt} * n16;
    end
    if (calc_branch) begin
      calc_total = calc_total + (f[`MACT_WCTL_HS_BIT] ? {8'h00, `MACT_FLUSH_FAST}
                                                      : {8'h00, `MACT_FLUSH_SLOW} + n16);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_st           = st;
    next_st.done      = 1'b0;
    next_st.err       = 1'b0;
    next_st.calc_done = 1'b0;
    next_st.arb       = ~st.arb;
    tmr_load          = 1'b0;
    tmr_val           = st.cycles;
    if (st.bus_cnt != 8'h00) begin
      next_st.bus_cnt = st.bus_cnt - 8'h01;
    end
    if (wctl_wr) begin
      next_st.wctl = wctl_data;
    end
    if (calc_valid) begin
      next_st.calc_clocks = calc_total;
      next_st.calc_done   = 1'b1;
    end
    case (st.state)
      ST_IDLE: begin
        if (req_valid) begin
          next_st.cycles   = req_cost;
          next_st.bus_hold = req_peripheral_ram_data ? `MACT_SLOW_BASE + {6'h00, req_n} : 8'h00;
          if (req_bad) begin
            next_st.done = 1'b1;
            next_st.err  = 1'b1;
          end else if (req_op == OP_IRQ_VEC || req_op == OP_IRQ_CTX) begin
            next_st.ready = 1'b0;
            next_st.state = ST_ARB;
          end else if (req_peripheral_ram_data && st.bus_cnt != 8'h00) begin
            next_st.ready = 1'b0;
            next_st.state = ST_STALL;
          end else begin
            if (req_peripheral_ram_data) begin
              next_st.bus_cnt = `MACT_SLOW_BASE + {6'h00, req_n};
            end
            tmr_load      = 1'b1;
            tmr_val       = req_cost;
            next_st.ready = 1'b0;
            next_st.state = ST_COUNT;
          end
        end
      end
      ST_ARB: begin
        if (st.arb) begin
          tmr_load      = 1'b1;
          next_st.state = ST_COUNT;
        end
      end
      ST_STALL: begin
        if (st.bus_cnt == 8'h00) begin
          next_st.bus_cnt = st.bus_hold;
          tmr_load        = 1'b1;
          next_st.state   = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (tmr_last) begin
          next_st.done  = 1'b1;
          next_st.ready = 1'b1;
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.ready = 1'b1;
        next_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st       <= '0;
      st.state <= ST_IDLE;
      st.ready <= 1'b1;
      st.wctl  <= `MACT_WCTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  mact_cycle_timer u_timer (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .load     (tmr_load),
    .load_val (tmr_val),
    .last     (tmr_last)
  );

  assign wait_control_reg = st.wctl;
  assign req_ready        = st.ready;
  assign acc_done         = st.done;
  assign acc_error        = st.err;
  assign acc_cycles       = st.cycles;
  assign calc_done        = st.calc_done;
  assign calc_clocks      = st.calc_clocks;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic take;
  assign take = req_valid && st.ready;

  sequence s_peripheral_ram_write;
    take && req_op == OP_WRITE && req_area == AREA_PERIPHERAL_RAM && st.bus_cnt == 8'h00;
  endsequence

  sequence s_bus_held;
    ##1 st.bus_cnt == `MACT_SLOW_BASE + {6'h00, $past(req_n)};
  endsequence

  chk_main_ram_time: assert property (
    take && !req_bad && req_area == AREA_MAIN && (req_op == OP_READ || req_op == OP_WRITE)
    |-> ##1 !acc_done ##1 acc_done && !acc_error)
    else $error("main RAM access not done in one clock");

  chk_fetch_fast: assert property (
    take && req_op == OP_FETCH && !req_bad && req_hs |-> ##2 !acc_done ##1 acc_done)
    else $error("high-speed fetch not two clocks");

  chk_fetch_denied: assert property (
    take && req_op == OP_FETCH && req_addr >= `MACT_MAIN_BASE |-> ##1 acc_error && acc_done)
    else $error("fetch from main RAM or SFR not refused");

  chk_rom_write_err: assert property (
    take && req_op == OP_WRITE && req_area == AREA_ROM |-> ##1 acc_error)
    else $error("ROM write not refused");

  chk_reset_mode: assert property (
    !$past(rst_b) |-> wait_control_reg == `MACT_WCTL_RESET)
    else $error("wait control not normal fetch after reset");

  chk_peripheral_ram_write_eu: assert property (
    s_peripheral_ram_write |-> s_bus_held ##1 acc_done)
    else $error("peripheral RAM write hand-off wrong");

  chk_peripheral_ram_stall: assert property (
    take && req_peripheral_ram_data && st.bus_cnt != 8'h00 && !req_bad
    |-> ##1 st.state == ST_STALL && !req_ready)
    else $error("peripheral RAM access did not wait for bus");

  chk_arb_slot: assert property (
    st.state == ST_ARB |-> ##[1:2] st.state == ST_COUNT)
    else $error("arbitration slot missed");

  chk_calc_fast: assert property (
    calc_valid && calc_fld[`MACT_WCTL_HS_BIT] && calc_class == CLS_NONE
    && calc_wctl_cnt == 4'h0 && !calc_branch
    |-> ##1 calc_done && calc_clocks == $past(calc_instr_clocks))
    else $error("high-speed basic count wrong");

endmodule : mact_top

// [testbench/mact_peripheral_ram_bus_model.sv]
// Bus occupancy model of the peripheral RAM side of the bus control unit
// Assumes take pulses mark requests accepted by the timing model
module mact_peripheral_ram_bus_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Accepted access
  input  wire logic       take,
  input  wire logic       peripheral_ram_hit,
  input  wire logic [1:0] wait_n,
  // Cycles left on the bus
  output logic      [3:0] busy_left
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_left <= 4'h0;
    end else if (take && peripheral_ram_hit) begin
      busy_left <= 4'h3 + {2'h0, wait_n};
    end else if (busy_left != 4'h0) begin
      busy_left <= busy_left - 4'h1;
    end
  end
endmodule : mact_peripheral_ram_bus_model

// [testbench/tb_memory_access_cycle_timing.sv]
// Self-checking bench of the memory access cycle timing model
// Assumes mact_pkg compiled first; one 250 MHz clock, synchronous reset
module tb_memory_access_cycle_timing import mact_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [11:0]  wctl;
    mact_op_type  op;
    logic [15:0]  addr;
    mact_svc_type svc;
    logic [7:0]   cost;
    logic         err;
    logic [1:0]   slack;
  } mact_row_type;

  logic           ref_clk = 1'b0;
  logic           rst_b = 1'b0;
  logic           wctl_wr = 1'b0;
  logic [11:0]    wctl_data = 12'h000;
  logic [11:0]    wait_control_reg;
  logic           req_valid = 1'b0;
  mact_op_type    req_op = OP_FETCH;
  logic [15:0]    req_addr = 16'h0000;
  mact_svc_type   req_svc = SVC_EVT;
  logic           req_ready;
  logic           acc_done;
  logic           acc_error;
  logic [7:0]     acc_cycles;
  logic           calc_valid = 1'b0;
  logic [1:0]     calc_region = 2'h0;
  logic [15:0]    calc_instr_clocks = 16'h0000;
  logic [7:0]     calc_instr_bytes = 8'h00;
  mact_class_type calc_class = CLS_NONE;
  logic [15:0]    calc_opnd_a = 16'h0000;
  logic [15:0]    calc_opnd_b = 16'h0000;
  logic [3:0]     calc_mm_cnt = 4'h0;
  logic [3:0]     calc_wctl_cnt = 4'h0;
  logic           calc_branch = 1'b0;
  logic           calc_done;
  logic [15:0]    calc_clocks;
  logic [3:0]     busy_left;
  logic [3:0]     busy_at_take;
  logic           err_seen;
  wire            take = req_valid & req_ready;
  wire            peripheral_ram_hit = (req_addr >= 16'hfc00) && (req_addr <= 16'hfdff)
                             && ((req_op == OP_READ) || (req_op == OP_WRITE));
  int             fails = 0;
  int             n_compared = 0;
  int             lat;

  localparam int NROW = 30;
  mact_row_type rows [NROW] = '{
    '{12'h000, OP_FETCH, 16'h0100, SVC_EVT, 8'h03, 1'b0, 2'h0},
    '{12'h003, OP_FETCH, 16'h0100, SVC_EVT, 8'h06, 1'b0, 2'h0},
    '{12'h004, OP_FETCH, 16'h0100, SVC_EVT, 8'h02, 1'b0, 2'h0},
    '{12'h600, OP_FETCH, 16'hfc00, SVC_EVT, 8'h06, 1'b0, 2'h0},
    '{12'h800, OP_FETCH, 16'hfc10, SVC_EVT, 8'h02, 1'b0, 2'h0},
    '{12'h000, OP_FETCH, 16'hfe00, SVC_EVT, 8'h00, 1'b1, 2'h0},
    '{12'h000, OP_FETCH, 16'h6000, SVC_EVT, 8'h00, 1'b1, 2'h0},
    '{12'h600, OP_READ, 16'hfe10, SVC_EVT, 8'h01, 1'b0, 2'h0},
    '{12'h600, OP_WRITE, 16'hfe12, SVC_EVT, 8'h01, 1'b0, 2'h0},
    '{12'h600, OP_READ, 16'hff00, SVC_EVT, 8'h04, 1'b0, 2'h0},
    '{12'h600, OP_WRITE, 16'hff80, SVC_EVT, 8'h04, 1'b0, 2'h0},
    '{12'h002, OP_READ, 16'h0200, SVC_EVT, 8'h05, 1'b0, 2'h0},
    '{12'h002, OP_WRITE, 16'h0200, SVC_EVT, 8'h00, 1'b1, 2'h0},
    '{12'h600, OP_READ, 16'hfc00, SVC_EVT, 8'h06, 1'b0, 2'h0},
    '{12'h000, OP_READ, 16'h7000, SVC_EVT, 8'h00, 1'b1, 2'h0},
    '{12'h600, OP_WRITE, 16'hfc04, SVC_EVT, 8'h01, 1'b0, 2'h0},
    '{12'h008, OP_READ, 16'h5ffe, SVC_EVT, 8'h04, 1'b0, 2'h0},
    '{12'h600, OP_IRQ_VEC, 16'hfe80, SVC_EVT, 8'h1b, 1'b0, 2'h2},
    '{12'h600, OP_IRQ_VEC, 16'hfc00, SVC_EVT, 8'h1f, 1'b0, 2'h2},
    '{12'h600, OP_IRQ_VEC, 16'hfc01, SVC_EVT, 8'h27, 1'b0, 2'h2},
    '{12'h000, OP_IRQ_VEC, 16'h0100, SVC_EVT, 8'h00, 1'b1, 2'h0},
    '{12'h600, OP_IRQ_CTX, 16'hfe80, SVC_EVT, 8'h17, 1'b0, 2'h2},
    '{12'h000, OP_MACRO, 16'h0000, SVC_EVT, 8'h0c, 1'b0, 2'h0},
    '{12'h000, OP_MACRO, 16'h0000, SVC_M2S_BYTE, 8'h12, 1'b0, 2'h0},
    '{12'h000, OP_MACRO, 16'h0000, SVC_M2S_WORD, 8'h13, 1'b0, 2'h0},
    '{12'h000, OP_MACRO, 16'h0000, SVC_S2M_BYTE, 8'h11, 1'b0, 2'h0},
    '{12'h000, OP_MACRO, 16'h0000, SVC_S2M_WORD, 8'h12, 1'b0, 2'h0},
    '{12'h000, OP_MACRO, 16'h0000, mact_svc_type'(3'h5), 8'h00, 1'b1, 2'h0},
    '{12'h004, OP_BRANCH, 16'h0100, SVC_EVT, 8'h08, 1'b0, 2'h0},
    '{12'h001, OP_BRANCH, 16'h0100, SVC_EVT, 8'h0b, 1'b0, 2'h0}
  };

  mact_top u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .wctl_wr(wctl_wr), .wctl_data(wctl_data),
    .wait_control_reg(wait_control_reg), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_svc(req_svc), .req_ready(req_ready), .acc_done(acc_done),
    .acc_error(acc_error), .acc_cycles(acc_cycles), .calc_valid(calc_valid),
    .calc_region(calc_region), .calc_instr_clocks(calc_instr_clocks),
    .calc_instr_bytes(calc_instr_bytes), .calc_class(calc_class),
    .calc_opnd_a(calc_opnd_a), .calc_opnd_b(calc_opnd_b), .calc_mm_cnt(calc_mm_cnt),
    .calc_wctl_cnt(calc_wctl_cnt), .calc_branch(calc_branch), .calc_done(calc_done),
    .calc_clocks(calc_clocks)
  );

  mact_peripheral_ram_bus_model u_bus (
    .ref_clk(ref_clk), .rst_b(rst_b), .take(take), .peripheral_ram_hit(peripheral_ram_hit),
    .wait_n(wait_control_reg[10:9]), .busy_left(busy_left)
  );

  always #2 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      fails++;
    end
  endtask : check

  task automatic set_wctl(input logic [11:0] w);
    @(posedge ref_clk);
    wctl_wr   <= 1'b1;
    wctl_data <= w;
    @(posedge ref_clk);
    wctl_wr <= 1'b0;
    @(posedge ref_clk);
    check("wait control", {4'h0, w}, {4'h0, wait_control_reg});
  endtask : set_wctl

  task automatic do_req(input mact_op_type op, input logic [15:0] addr,
                        input mact_svc_type svc);
    int guard;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= addr;
    req_svc   <= svc;
    guard = 0;
    do begin
      @(posedge ref_clk);
      guard++;
    end while (req_ready !== 1'b1 && guard < 200);
    busy_at_take = busy_left;
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (acc_done !== 1'b1 && lat < 200);
    err_seen = acc_error;
  endtask : do_req

  task automatic do_calc(input logic [1:0] rg, input logic [15:0] clks, input logic [7:0] nb,
                         input mact_class_type cls, input logic [15:0] a, input logic [15:0] b,
                         input logic [3:0] mm, input logic [3:0] wc, input logic br,
                         input logic [15:0] exp);
    @(posedge ref_clk);
    calc_valid        <= 1'b1;
    calc_region       <= rg;
    calc_instr_clocks <= clks;
    calc_instr_bytes  <= nb;
    calc_class        <= cls;
    calc_opnd_a       <= a;
    calc_opnd_b       <= b;
    calc_mm_cnt       <= mm;
    calc_wctl_cnt     <= wc;
    calc_branch       <= br;
    @(posedge ref_clk);
    calc_valid <= 1'b0;
    @(posedge ref_clk);
    check("calc done", 16'h0001, {15'h0, calc_done});
    check("calc clocks", exp, calc_clocks);
  endtask : do_calc

  task automatic finish_test();
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    check("reset wait control", 16'h0000, {4'h0, wait_control_reg});
    check("reset ready", 16'h0001, {15'h0, req_ready});
    check("reset done", 16'h0000, {15'h0, acc_done});
    check("reset calc", 16'h0000, calc_clocks);
    for (int i = 0; i < NROW; i++) begin
      set_wctl(rows[i].wctl);
      do_req(rows[i].op, rows[i].addr, rows[i].svc);
      check("refusal", {15'h0, rows[i].err}, {15'h0, err_seen});
      if (rows[i].err === 1'b0) begin
        check("cycles", {8'h0, rows[i].cost}, {8'h0, acc_cycles});
        check("latency ok", 16'h0001, {15'h0, (lat >= rows[i].cost + 1) &&
              (lat <= rows[i].cost + 1 + rows[i].slack)});
      end else begin
        check("refused latency", 16'h0001, lat[15:0]);
      end
    end
    // Peripheral read right behind a peripheral write
    set_wctl(12'h600);
    do_req(OP_WRITE, 16'hfc00, SVC_EVT);
    check("write latency", 16'h0002, lat[15:0]);
    do_req(OP_READ, 16'hfc02, SVC_EVT);
    check("bus busy at take", 16'h0001, {15'h0, busy_at_take != 4'h0});
    check("stalled read", 16'h0001, {15'h0, (lat >= 8) &&
          (lat <= 8 + busy_at_take)});
    // Execution clock calculation
    set_wctl(12'h004);
    do_calc(2'h0, 16'h000e, 8'h04, CLS_NONE, 16'h0, 16'h0, 4'h0, 4'h0, 1'b0, 16'h000e);
    do_calc(2'h0, 16'h000e, 8'h04, CLS_NONE, 16'h0, 16'h0, 4'h2, 4'h3, 1'b0, 16'h0011);
    do_calc(2'h0, 16'h000e, 8'h04, CLS_NONE, 16'h0, 16'h0, 4'h0, 4'h0, 1'b1, 16'h0016);
    set_wctl(12'h001);
    do_calc(2'h0, 16'h000e, 8'h04, CLS_NONE, 16'h0, 16'h0, 4'h0, 4'h0, 1'b0, 16'h0010);
    do_calc(2'h1, 16'h000e, 8'h06, CLS_NONE, 16'h0, 16'h0, 4'h0, 4'h0, 1'b0, 16'h0012);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_SINGLE, 16'hff10, 16'h0, 4'h0, 4'h0, 1'b0, 16'h0018);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_SINGLE, 16'hff20, 16'h0, 4'h0, 4'h0, 1'b0, 16'h0014);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_DOUBLE, 16'hff1f, 16'h0, 4'h0, 4'h0, 1'b0, 16'h001c);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_MEMMEM, 16'hff00, 16'hff1f, 4'h0, 4'h0, 1'b0, 16'h001c);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_MEMMEM, 16'hfe00, 16'hff1f, 4'h0, 4'h0, 1'b0, 16'h0018);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_NONE, 16'h0, 16'h0, 4'h2, 4'h3, 1'b0, 16'h0016);
    do_calc(2'h0, 16'h0014, 8'h01, CLS_NONE, 16'h0, 16'h0, 4'h0, 4'h0, 1'b1, 16'h001f);
    // Reset in mid-run returns every block to normal fetch
    set_wctl(12'h924);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    check("mid reset wait control", 16'h0000, {4'h0, wait_control_reg});
    do_req(OP_FETCH, 16'h0100, SVC_EVT);
    check("fetch after reset", 16'h0003, {8'h0, acc_cycles});
    finish_test();
  end
endmodule : tb_memory_access_cycle_timing
